// File: src/lvi_pkg.sv
package lvi_pkg;
    // ======================================================================
    // Sizes
    localparam int LVI_LEVELS     = 8;
    localparam int LVI_SOURCES    = 12;
    localparam int LVI_MAX_VEC    = 128;
    localparam int LVI_PRIO_W     = 8;

    // ======================================================================
    // Source to level and vector map, index is source number
    localparam logic [LVI_SOURCES*3-1:0] LVI_SRC_LEVEL = {
        3'h7, 3'h7, 3'h7, 3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0, 3'h0};
    localparam logic [LVI_SOURCES*8-1:0] LVI_SRC_VEC = {
        8'hEE, 8'hEC, 8'hEA, 8'hE8, 8'hE6, 8'hE4, 8'hE2, 8'hE0, 8'hF6, 8'hF4, 8'hF2, 8'hF0};
    // Sources whose pending flag hardware clears on acknowledge
    localparam logic [LVI_SOURCES-1:0] LVI_HW_CLEAR = 12'h000;

    // ======================================================================
    // Priority register fields
    localparam int LVI_GRP_LO     = 0;
    localparam int LVI_GRP_HI     = 2;
    localparam int LVI_SUBA       = 3;
    localparam int LVI_SUBB       = 4;
    localparam int LVI_SUBC       = 5;
    localparam int LVI_SUBD       = 6;
    localparam int LVI_SUBE       = 7;

    typedef enum logic [1:0] {
        LVI_IDLE,
        LVI_FETCH_HI,
        LVI_FETCH_LO,
        LVI_SERVICE
    } lvi_state_e;

    typedef struct packed {
        logic [7:0]  vector;
        logic [2:0]  level;
        logic [15:0] isrAddr;
    } lvi_grant_s;
endpackage

// File: src/lvi_level_arbiter.sv
`timescale 1ns/1ps
module lvi_level_arbiter
    import lvi_pkg::*;
(
    // Requests per level
    input  wire logic [LVI_LEVELS-1:0] levelReq,
    // Priority setting
    input  wire logic [LVI_PRIO_W-1:0] levelPriority,
    // Winner
    output logic      [2:0]            winLevel,
    output logic                       winValid
);
    // ======================================================================
    // Group and subgroup arbitration
    // Levels split into three groups A B C of two, three and three levels
    // A={0,1}, B={2,3,4}, C={5,6,7}; subA, subBb, subCb swap two members, subB and subC move the first member last.
    wire logic [2:0] grpOrd  = levelPriority[LVI_GRP_HI:LVI_GRP_LO];
    wire logic       subA    = levelPriority[LVI_SUBA];
    wire logic       subB    = levelPriority[LVI_SUBB];
    wire logic       subBb   = levelPriority[LVI_SUBC];
    wire logic       subC    = levelPriority[LVI_SUBD];
    wire logic       subCb   = levelPriority[LVI_SUBE];

    function automatic logic [3:0] pick3(input logic [2:0] r, input logic [2:0] l0,
                                         input logic [2:0] l1, input logic [2:0] l2);
        if (r[0]) begin
            return {1'b1, l0};
        end else if (r[1]) begin
            return {1'b1, l1};
        end else if (r[2]) begin
            return {1'b1, l2};
        end
        return 4'h0;
    endfunction

    wire logic [3:0] winA = subA ? pick3({1'b0, levelReq[0], levelReq[1]}, 3'h1, 3'h0, 3'h0)
                                 : pick3({1'b0, levelReq[1], levelReq[0]}, 3'h0, 3'h1, 3'h0);
    wire logic [3:0] winB = subB ? pick3({levelReq[2], levelReq[4], levelReq[3]}, 3'h3, 3'h4, 3'h2)
                                 : (subBb ? pick3({levelReq[3], levelReq[4], levelReq[2]}, 3'h2, 3'h4, 3'h3)
                                          : pick3({levelReq[4], levelReq[3], levelReq[2]}, 3'h2, 3'h3, 3'h4));
    wire logic [3:0] winC = subC ? pick3({levelReq[5], levelReq[7], levelReq[6]}, 3'h6, 3'h7, 3'h5)
                                 : (subCb ? pick3({levelReq[6], levelReq[7], levelReq[5]}, 3'h5, 3'h7, 3'h6)
                                          : pick3({levelReq[7], levelReq[6], levelReq[5]}, 3'h5, 3'h6, 3'h7));

    // Group order; codes 0, 6 and 7 fall back to A>B>C
    logic [3:0] pick;
    always_comb begin
        unique case (grpOrd)
            3'h1:    pick = winC[3] ? winC : (winB[3] ? winB : winA);
            3'h2:    pick = winA[3] ? winA : (winC[3] ? winC : winB);
            3'h3:    pick = winB[3] ? winB : (winC[3] ? winC : winA);
            3'h4:    pick = winC[3] ? winC : (winA[3] ? winA : winB);
            3'h5:    pick = winB[3] ? winB : (winA[3] ? winA : winC);
            default: pick = winA[3] ? winA : (winB[3] ? winB : winC);
        endcase
    end
    assign winValid = pick[3];
    assign winLevel = pick[2:0];
endmodule

// File: src/lvi_controller.sv
`timescale 1ns/1ps
// Functional notes
// - Eight request levels 0 to 7 exist, each one request number toward the CPU.
// - Each level drives exactly one level request line.
// - A level number carries no priority; the priority setting alone orders levels.
// - The priority setting steers group and subgroup arbitration among levels.
// - Vectors are 8-bit codes, so up to 128 even vectors fit the architecture.
// - A level may carry no vector or up to 128 vectors.
// - Ordering among vectors of one level is fixed in hardware.
// - Any vector may be shared by one or more sources.
// - Twelve sources use twelve vectors spread over eight levels.
// - Every peripheral, pin event or overflow may raise a request.
// - Pending flags clear at service start by hardware or by software per source.
// - Each level is a single source, shared vector, or multi-vector arrangement.
// - Only two arrangements are used here: one vector one source, and several vectors.
// - Within a level the lowest vector address wins.
// - Once a request is accepted all other interrupts are masked during stacking.
// - The routine address is the vector byte followed by the next byte.
module lvi_controller
    import lvi_pkg::*;
#(
    parameter int NUM_SOURCES = LVI_SOURCES
)(
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset,
    // Sources
    input  wire logic [NUM_SOURCES-1:0]    srcEvent,
    input  wire logic [NUM_SOURCES-1:0]    srcEnable,
    input  wire logic [NUM_SOURCES-1:0]    swClear,
    input  wire logic [LVI_PRIO_W-1:0]     levelPriority,
    // CPU side
    input  wire logic                      globalEnable,
    input  wire logic                      cpuAck,
    input  wire logic                      serviceDone,
    input  wire logic [7:0]                romData,
    output logic      [7:0]                romAddr,
    output logic      [LVI_LEVELS-1:0]     levelRequestLine,
    output logic                           cpuRequest,
    output lvi_grant_s                     grant,
    output logic                           grantValid,
    output logic      [NUM_SOURCES-1:0]    pending
);
    // ======================================================================
    // Parameter check
    generate
        if (NUM_SOURCES != LVI_SOURCES) begin : gBadSources
            $error("NUM_SOURCES must match the fixed source map");
        end
    endgenerate

    // ======================================================================
    // Pending flags
    lvi_state_e state;
    lvi_state_e next_state;
    logic [NUM_SOURCES-1:0] ackClear;
    wire logic [NUM_SOURCES-1:0] active = pending & srcEnable;

    genvar g;
    generate
        for (g = 0; g < NUM_SOURCES; g++) begin : gPend
            // Set wins over any clear so a coincident event is never lost
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    pending[g] <= 1'b0;
                end else begin
                    pending[g] <= srcEvent[g] | (pending[g] & ~swClear[g] & ~ackClear[g]);
                end
            end
        end
    endgenerate

    function automatic logic [2:0] srcLevel(input int s);
        return LVI_SRC_LEVEL[s*3 +: 3];
    endfunction
    function automatic logic [7:0] srcVec(input int s);
        return LVI_SRC_VEC[s*8 +: 8];
    endfunction

    // ======================================================================
    // Level requests: OR of active sources mapped to each level
    always_comb begin
        levelRequestLine = '0;
        for (int s = 0; s < NUM_SOURCES; s++) begin
            if (active[s]) begin
                levelRequestLine[srcLevel(s)] = 1'b1;
            end
        end
    end

    wire logic [2:0] winLevel;
    wire logic       winValid;
    lvi_level_arbiter uArb (
        .levelReq      (levelRequestLine),
        .levelPriority (levelPriority),
        .winLevel      (winLevel),
        .winValid      (winValid)
    );

    // ======================================================================
    // Lowest vector within the winning level, fixed order
    logic [7:0] winVec;
    logic [NUM_SOURCES-1:0] winSrcs;
    logic       vecFound;
    always_comb begin
        winVec   = 8'hFF;
        vecFound = 1'b0;
        winSrcs  = '0;
        for (int s = 0; s < NUM_SOURCES; s++) begin
            if (active[s] && srcLevel(s) == winLevel && (!vecFound || srcVec(s) < winVec)) begin
                winVec   = srcVec(s);
                vecFound = 1'b1;
            end
        end
        for (int s = 0; s < NUM_SOURCES; s++) begin
            if (vecFound && srcVec(s) == winVec) begin
                winSrcs[s] = 1'b1;
            end
        end
    end

    // ======================================================================
    // Acceptance and vector fetch
    logic [7:0]  vecHeld;
    logic [7:0]  addrHi;
    assign cpuRequest = (state == LVI_IDLE) && globalEnable && winValid;
    wire logic take   = cpuRequest && cpuAck;
    assign ackClear   = take ? (winSrcs & LVI_HW_CLEAR) : '0;

    always_comb begin
        next_state = state;
        unique case (state)
            LVI_IDLE:     if (take) next_state = LVI_FETCH_HI;
            LVI_FETCH_HI: next_state = LVI_FETCH_LO;
            LVI_FETCH_LO: next_state = LVI_SERVICE;
            LVI_SERVICE:  if (serviceDone) next_state = LVI_IDLE;
        endcase
    end

    assign romAddr = (state == LVI_FETCH_LO) ? vecHeld + 8'h01 : vecHeld;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= LVI_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            vecHeld  <= 8'h00;
            addrHi   <= 8'h00;
            grant    <= '0;
        end else begin
            if (take) begin
                vecHeld     <= winVec;
                grant.level <= winLevel;
                grant.vector <= winVec;
            end
            if (state == LVI_FETCH_HI) begin
                addrHi <= romData;
            end
            if (state == LVI_FETCH_LO) begin
                grant.isrAddr <= {addrHi, romData};
            end
        end
    end
    assign grantValid = (state == LVI_SERVICE);

    // ======================================================================
    // Checks on acceptance and masking
    wire logic [NUM_SOURCES-1:0] clearOnly = swClear & ~srcEvent;

    request_masked_a: assert property (@(posedge clk) disable iff (reset)
        (state != LVI_IDLE) |-> !cpuRequest)
        else $error("request while busy");

    no_request_off_a: assert property (@(posedge clk) disable iff (reset)
        (!globalEnable) |-> !cpuRequest)
        else $error("request while disabled");

    idle_no_grant_a: assert property (@(posedge clk) disable iff (reset)
        (state == LVI_IDLE) |-> !grantValid)
        else $error("grant while idle");

    ack_ignored_a: assert property (@(posedge clk) disable iff (reset)
        (state == LVI_IDLE && cpuAck && !cpuRequest) |=> (state == LVI_IDLE))
        else $error("refused acknowledge taken");

    service_holds_a: assert property (@(posedge clk) disable iff (reset)
        (grantValid && !serviceDone) |=> grantValid)
        else $error("service ended early");

    service_ends_a: assert property (@(posedge clk) disable iff (reset)
        (grantValid && serviceDone) |=> (state == LVI_IDLE))
        else $error("service did not end");

    grant_request_a: assert property (@(posedge clk) disable iff (reset)
        take |-> winValid)
        else $error("take without a winner");

    // ======================================================================
    // Checks on the vector fetch
    fetch_sequence_a: assert property (@(posedge clk) disable iff (reset)
        take |=> (state == LVI_FETCH_HI) ##1 (state == LVI_FETCH_LO) ##1 grantValid)
        else $error("vector fetch sequence wrong");

    rom_high_a: assert property (@(posedge clk) disable iff (reset)
        (state == LVI_FETCH_HI) |-> (romAddr == vecHeld))
        else $error("high byte address wrong");

    rom_low_a: assert property (@(posedge clk) disable iff (reset)
        (state == LVI_FETCH_LO) |-> (romAddr == vecHeld + 8'h01))
        else $error("low byte address wrong");

    addr_assembled_a: assert property (@(posedge clk) disable iff (reset)
        (state == LVI_FETCH_LO) |=> (grant.isrAddr == {$past(addrHi), $past(romData)}))
        else $error("routine address wrong");

    grant_stable_a: assert property (@(posedge clk) disable iff (reset)
        (grantValid && $past(grantValid)) |-> $stable(grant))
        else $error("grant changed in service");

    grant_level_a: assert property (@(posedge clk) disable iff (reset)
        take |=> (grant.level == $past(winLevel)))
        else $error("grant level wrong");

    grant_vector_a: assert property (@(posedge clk) disable iff (reset)
        take |=> (grant.vector == $past(winVec)))
        else $error("grant vector wrong");

    // ======================================================================
    // Checks on pending flags and level lines
    event_kept_a: assert property (@(posedge clk) disable iff (reset)
        srcEvent[0] |=> pending[0])
        else $error("event lost");

    events_kept_a: assert property (@(posedge clk) disable iff (reset)
        (|srcEvent) |=> ((pending & $past(srcEvent)) == $past(srcEvent)))
        else $error("event lost on some source");

    sw_clear_a: assert property (@(posedge clk) disable iff (reset)
        (swClear[1] && !srcEvent[1]) |=> !pending[1])
        else $error("clear ignored");

    clears_all_a: assert property (@(posedge clk) disable iff (reset)
        (|clearOnly) |=> ((pending & $past(clearOnly)) == '0))
        else $error("clear ignored on some source");

    pending_rise_a: assert property (@(posedge clk) disable iff (reset)
        1'b1 |=> ((pending & ~$past(pending) & ~$past(srcEvent)) == '0))
        else $error("pending without event");

    soft_clear_only_a: assert property (@(posedge clk) disable iff (reset)
        (ackClear & ~LVI_HW_CLEAR) == '0)
        else $error("hardware cleared a software source");

    ack_clear_idle_a: assert property (@(posedge clk) disable iff (reset)
        (!take) |-> (ackClear == '0))
        else $error("clear without acceptance");

    gated_request_a: assert property (@(posedge clk) disable iff (reset)
        levelRequestLine[0] |-> (active[0] | active[1]))
        else $error("level 0 without source");

    any_request_a: assert property (@(posedge clk) disable iff (reset)
        (|levelRequestLine) == (|active))
        else $error("level lines disagree with sources");

    level_one_a: assert property (@(posedge clk) disable iff (reset)
        levelRequestLine[1] == active[2])
        else $error("level 1 line wrong");

    level_three_a: assert property (@(posedge clk) disable iff (reset)
        levelRequestLine[3] == active[4])
        else $error("level 3 line wrong");

    level_six_a: assert property (@(posedge clk) disable iff (reset)
        levelRequestLine[6] == active[7])
        else $error("level 6 line wrong");

    top_level_a: assert property (@(posedge clk) disable iff (reset)
        levelRequestLine[7] == (|active[11:8]))
        else $error("level 7 line wrong");

    // ======================================================================
    // Checks on arbitration
    win_valid_a: assert property (@(posedge clk) disable iff (reset)
        winValid == (|levelRequestLine))
        else $error("winner flag wrong");

    win_requested_a: assert property (@(posedge clk) disable iff (reset)
        winValid |-> levelRequestLine[winLevel])
        else $error("winner level not requesting");

    vec_found_a: assert property (@(posedge clk) disable iff (reset)
        winValid |-> vecFound)
        else $error("no vector for winning level");

    shared_sources_a: assert property (@(posedge clk) disable iff (reset)
        vecFound |-> (winSrcs != '0))
        else $error("vector without source");

    lowest_vector_a: assert property (@(posedge clk) disable iff (reset)
        (cpuRequest && winLevel == 3'h0 && active[0]) |-> (winVec == srcVec(0)))
        else $error("level vector order wrong");

    fixed_order_a: assert property (@(posedge clk) disable iff (reset)
        (cpuRequest && winLevel == 3'h7 && active[8]) |-> (winVec == srcVec(8)))
        else $error("level 7 vector order wrong");
endmodule

// File: bench/lvi_cpu_model.sv
`timescale 1ns/1ps
// ======================================================================
// CPU core: accepts requests, reads the vector table, ends service
module lvi_cpu_model (
    // Clock
    input  wire logic       clk,
    // Controller side
    input  wire logic       cpuRequest,
    input  wire logic       grantValid,
    input  wire logic [7:0] romAddr,
    input  wire logic       slowAck,
    output logic            cpuAck,
    output logic            serviceDone,
    output logic [7:0]      romData
);
    int waitCnt = 0;
    int svcCnt  = 0;
    // Table bytes are a scramble of the address, so high and low bytes differ
    assign romData = romAddr ^ 8'h5A;
    initial begin
        cpuAck = 1'b0;
        serviceDone = 1'b0;
    end
    // Slow mode lets a request wait several cycles before it is taken
    always @(negedge clk) begin
        waitCnt = cpuRequest ? waitCnt + 1 : 0;
        cpuAck <= cpuRequest && waitCnt > (slowAck ? 3 : 0);
        svcCnt = grantValid ? svcCnt + 1 : 0;
        serviceDone <= (svcCnt == 4);
    end
endmodule

// File: bench/test_leveled_vectored_interrupt_logic.sv
`timescale 1ns/1ps
module test_leveled_vectored_interrupt_logic;
    import lvi_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [11:0] srcEvent = '0;
    logic [11:0] srcEnable = 12'hFFF;
    logic [11:0] swClear = '0;
    logic [7:0]  levelPriority = '0;
    logic        globalEnable = 1'b0;
    logic        slowAck = 1'b0;
    logic        cpuAck, serviceDone, cpuRequest, grantValid;
    logic [7:0]  romData, romAddr, levelRequestLine;
    logic [11:0] pending;
    lvi_grant_s  grant;
    int          fails = 0;
    int          compares = 0;
    int          cycles = 0;

    always #20 clk = ~clk;

    lvi_controller dut_u (.clk(clk), .reset(reset), .srcEvent(srcEvent), .srcEnable(srcEnable),
        .swClear(swClear), .levelPriority(levelPriority), .globalEnable(globalEnable), .cpuAck(cpuAck),
        .serviceDone(serviceDone), .romData(romData), .romAddr(romAddr), .levelRequestLine(levelRequestLine),
        .cpuRequest(cpuRequest), .grant(grant), .grantValid(grantValid), .pending(pending));
    lvi_cpu_model cpu_u (.clk(clk), .cpuRequest(cpuRequest), .grantValid(grantValid), .romAddr(romAddr),
        .slowAck(slowAck), .cpuAck(cpuAck), .serviceDone(serviceDone), .romData(romData));

    // ======================================================================
    // Checking and closing
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task close_out;
        $display("Counts: %0d compares, %0d fails", compares, fails);
        if (fails == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Whole run needs several hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            close_out;
        end
    end

    // ======================================================================
    // Shared steps
    task raise(input logic [11:0] m);
        @(negedge clk);
        srcEvent = m;
        @(negedge clk);
        srcEvent = '0;
    endtask

    // Waits for the grant of source s, checks it, clears it and waits for service to end
    task serve(input int s);
        logic [7:0] ev;
        int n;
        ev = LVI_SRC_VEC[s*8+:8];
        n = 0;
        while (grantValid !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        chk("granted", 16'h1, {15'h0, grantValid});
        chk("vector", {8'h00, ev}, {8'h00, grant.vector});
        chk("level", {13'h0, LVI_SRC_LEVEL[s*3+:3]}, {13'h0, grant.level});
        chk("isr", {ev ^ 8'h5A, (ev + 8'h01) ^ 8'h5A}, grant.isrAddr);
        chk("masked", 16'h0, {15'h0, cpuRequest});
        swClear[s] = 1'b1;
        @(negedge clk);
        swClear = '0;
        chk("cleared", 16'h0, {15'h0, pending[s]});
        n = 0;
        while (grantValid !== 1'b0 && n < 50) begin
            @(negedge clk);
            n++;
        end
    endtask

    task pri(input logic [7:0] p, input int a, input int b);
        levelPriority = p;
        globalEnable = 1'b0;
        raise((12'h1 << a) | (12'h1 << b));
        globalEnable = 1'b1;
        serve(b);
        serve(a);
    endtask

    // ======================================================================
    // Scenarios
    task test_reset;
        chk("pending", 16'h0, {4'h0, pending});
        chk("grantValid", 16'h0, {15'h0, grantValid});
        chk("lines", 16'h0, {8'h00, levelRequestLine});
        $display("test_reset done");
    endtask

    // A pending source stays silent until enabled
    task test_enable;
        srcEnable = 12'h000;
        globalEnable = 1'b1;
        raise(12'h001);
        #1;
        chk("pending", 16'h1, {4'h0, pending});
        chk("lines", 16'h0, {8'h00, levelRequestLine});
        chk("request", 16'h0, {15'h0, cpuRequest});
        srcEnable = 12'hFFF;
        #1;
        chk("lines", 16'h1, {8'h00, levelRequestLine});
        serve(0);
        $display("test_enable done");
    endtask

    // Every source alone, fast and slow acknowledge, global enable held off first
    task test_sweep;
        for (int s = 0; s < 12; s++) begin
            slowAck = s[0];
            globalEnable = 1'b0;
            raise(12'h1 << s);
            #1;
            chk("lines", {8'h00, 8'h1 << LVI_SRC_LEVEL[s*3+:3]}, {8'h00, levelRequestLine});
            chk("refused", 16'h0, {15'h0, cpuRequest});
            globalEnable = 1'b1;
            serve(s);
        end
        slowAck = 1'b0;
        $display("test_sweep done");
    endtask

    // Contenders in one level come out in vector order
    task test_within;
        globalEnable = 1'b0;
        raise(12'hF03);
        globalEnable = 1'b1;
        serve(0);
        serve(1);
        for (int s = 8; s < 12; s++)
            serve(s);
        $display("test_within done");
    endtask

    task test_levels;
        pri(8'h00, 6, 0);
        pri(8'h01, 0, 6);
        pri(8'h02, 3, 6);
        pri(8'h03, 0, 3);
        pri(8'h04, 3, 0);
        pri(8'h05, 0, 3);
        pri(8'h08, 0, 2);
        pri(8'h00, 2, 0);
        pri(8'h06, 6, 0);
        pri(8'h07, 3, 0);
        pri(8'h10, 3, 4);
        pri(8'h20, 4, 5);
        pri(8'h40, 6, 7);
        pri(8'h80, 7, 8);
        $display("test_levels done");
    endtask

    initial begin
        repeat (6) @(negedge clk);
        reset = 1'b0;
        test_reset;
        test_enable;
        test_sweep;
        test_within;
        test_levels;
        close_out;
    end
endmodule
